//--- include/ext_insn_pkg.sv
package ext_insn_pkg;

    // Instruction encodings
    localparam logic [7:0]  op_add_pointer      = 8'he8;
    localparam logic [7:0]  op_sub_pointer      = 8'he9;
    localparam logic [7:0]  op_push_literal     = 8'hea;
    localparam logic [7:0]  op_move_indexed     = 8'heb;
    localparam logic [15:0] op_call_via_working = 16'h0014;
    localparam logic [3:0]  second_word_nibble  = 4'hf;
    localparam logic [1:0]  sel_return_form     = 2'h3;
    localparam int          move_kind_bit       = 7;

    // Indirect addressing registers sit at these data addresses
    localparam logic [11:0] indirect_base_0     = 12'hfef;
    localparam logic [11:0] indirect_base_1     = 12'hfe7;
    localparam logic [11:0] indirect_base_2     = 12'hfdf;
    localparam logic [2:0]  indirect_span       = 3'h4;
    localparam logic [11:0] pointer_reset       = 12'h000;
    localparam logic [7:0]  indirect_read_value = 8'h00;
    localparam logic [20:0] return_step         = 21'h000002;

    typedef enum logic [1:0] {
        st_execute   = 2'b00,
        st_dead      = 2'b01,
        st_move_dest = 2'b10
    } phase_e;

    // Data memory request
    typedef struct packed {
        logic        read;
        logic [11:0] read_addr;
        logic        write;
        logic [11:0] write_addr;
        logic [7:0]  write_data;
    } mem_req_s;

    // Program counter and stack requests
    typedef struct packed {
        logic        load;
        logic [20:0] value;
        logic        push;
        logic [20:0] push_value;
        logic        pop_to_pc;
    } flow_req_s;

    typedef struct packed {
        phase_e      phase;
        logic        move_kind;
        logic [11:0] source_addr;
        logic [11:0] pointer_0;
        logic [11:0] pointer_1;
        logic [11:0] pointer_2;
        mem_req_s    mem;
        flow_req_s   flow;
        logic        handled;
        logic        busy;
    } unit_state_s;

endpackage : ext_insn_pkg

//--- hw/extended_indexed_instruction_unit.sv
`timescale 1ns/1ps
module extended_indexed_instruction_unit (
    // Clock and reset
    input  wire logic                    mclk,
    input  wire logic                    reset,
    // Configuration
    input  wire logic                    extended_set_enable,
    // Instruction from fetch
    input  wire logic                    insn_valid,
    input  wire logic [15:0]             insn_word,
    input  wire logic [20:0]             program_counter,
    // Core registers
    input  wire logic [7:0]              working_register,
    input  wire logic [7:0]              counter_high_latch,
    input  wire logic [7:0]              counter_upper_latch,
    // Data memory read return, sampled in the same cycle that the read request is on mem_req
    input  wire logic [7:0]              mem_read_data,
    // Outputs to core
    output ext_insn_pkg::mem_req_s       mem_req,
    output ext_insn_pkg::flow_req_s      flow_req,
    output logic [11:0]                  file_select_pointer_0,
    output logic [11:0]                  file_select_pointer_1,
    output logic [11:0]                  third_pointer,
    output logic                         insn_handled,
    output logic                         insn_busy
);
    import ext_insn_pkg::*;

    unit_state_s state;
    unit_state_s next_state;

    // Word decode, shared by the execute phase
    logic        word_taken;
    logic        is_add;
    logic        is_sub;
    logic        is_pointer_op;
    logic        is_call;
    logic        is_push;
    logic        is_move;
    logic        is_operand;

    // Third pointer plus the seven-bit offset of the current word
    logic [11:0] indexed_addr;
    logic [2:0]  source_window_hit;
    logic [2:0]  dest_window_hit;
    logic        source_indirect;
    logic        dest_indirect;

    // Each window runs from its base down four slots, plus-literal slot included
    localparam logic [2:0][11:0] window_base = {indirect_base_2, indirect_base_1,
                                                indirect_base_0};

    // Disabled set: every word passes through untouched
    // Dead and operand cycles are handled by phase, not by this decode
    assign word_taken    = insn_valid && extended_set_enable;
    assign is_add        = insn_word[15:8] == op_add_pointer;
    assign is_sub        = insn_word[15:8] == op_sub_pointer;
    assign is_pointer_op = is_add || is_sub;
    assign is_call       = insn_word == op_call_via_working;
    assign is_push       = insn_word[15:8] == op_push_literal;
    assign is_move       = insn_word[15:8] == op_move_indexed;
    // An operand word met outside a move is claimed and dropped
    assign is_operand    = insn_word[15:12] == second_word_nibble;

    // Full 12-bit sum wraps inside the data space, so any byte is reachable
    assign indexed_addr  = state.pointer_2 + {5'h00, insn_word[6:0]};

    // Source and destination are matched apart: they are different addresses
    for (genvar i = 0; i < 3; i++) begin : g_window
        assign source_window_hit[i] = state.source_addr <= window_base[i]
            && state.source_addr >= window_base[i] - 12'(indirect_span);
        assign dest_window_hit[i]   = indexed_addr <= window_base[i]
            && indexed_addr >= window_base[i] - 12'(indirect_span);
    end

    assign source_indirect = |source_window_hit;
    assign dest_indirect   = |dest_window_hit;

    always_comb begin
        logic [1:0]  sel;
        logic [11:0] lit6;
        logic [11:0] sel_ptr;
        logic [11:0] moved;
        sel = insn_word[7:6];
        lit6 = {6'h00, insn_word[5:0]};
        sel_ptr = state.pointer_2;
        moved = 12'h000;
        next_state = state;
        // Pulse outputs fall back to idle unless a branch raises them
        next_state.mem = '0;
        next_state.flow = '0;
        next_state.handled = 1'b0;
        next_state.busy = 1'b0;
        case (state.phase)
            st_execute: begin
                if (word_taken) begin
                    // Selector 11 lands on the third pointer; the return is added below
                    case (sel)
                        2'h0: sel_ptr = state.pointer_0;
                        2'h1: sel_ptr = state.pointer_1;
                        default: sel_ptr = state.pointer_2;
                    endcase
                    if (is_pointer_op) begin
                        next_state.handled = 1'b1;
                        if (is_add)
                            moved = sel_ptr + lit6;
                        else
                            moved = sel_ptr - lit6;
                        case (sel)
                            2'h0: next_state.pointer_0 = moved;
                            2'h1: next_state.pointer_1 = moved;
                            default: next_state.pointer_2 = moved;
                        endcase
                        if (sel == sel_return_form) begin
                            next_state.flow.pop_to_pc = 1'b1;
                            next_state.busy = 1'b1;
                            next_state.phase = st_dead;
                        end
                    end else if (is_call) begin
                        // Working, status and bank registers are never driven here
                        next_state.handled = 1'b1;
                        next_state.flow.push = 1'b1;
                        next_state.flow.push_value = program_counter + return_step;
                        next_state.flow.load = 1'b1;
                        // Upper latch keeps only the bits that fit the 21-bit counter
                        next_state.flow.value = {5'(counter_upper_latch), counter_high_latch,
                                                 working_register};
                        next_state.busy = 1'b1;
                        next_state.phase = st_dead;
                    end else if (is_push) begin
                        next_state.handled = 1'b1;
                        next_state.mem.write = 1'b1;
                        next_state.mem.write_addr = state.pointer_2;
                        next_state.mem.write_data = insn_word[7:0];
                        next_state.pointer_2 = state.pointer_2 - 12'h001;
                    end else if (is_move) begin
                        // Source byte is read now and written in the operand cycle
                        next_state.handled = 1'b1;
                        next_state.busy = 1'b1;
                        next_state.move_kind = insn_word[move_kind_bit];
                        // Full 12-bit sum wraps inside the data space
                        next_state.source_addr = state.pointer_2
                                               + {5'h00, insn_word[6:0]};
                        next_state.mem.read = 1'b1;
                        next_state.mem.read_addr = next_state.source_addr;
                        next_state.phase = st_move_dest;
                    end else if (is_operand) begin
                        next_state.handled = 1'b1;
                    end
                end
            end
            st_dead: begin
                // Fetch of the new target overlaps this idle cycle
                next_state.handled = 1'b1;
                next_state.phase = st_execute;
            end
            st_move_dest: begin
                // Operand word, never decoded as an instruction
                next_state.handled = 1'b1;
                next_state.phase = st_execute;
                next_state.mem.write = 1'b1;
                next_state.mem.write_data = source_indirect
                                          ? indirect_read_value : mem_read_data;
                if (state.move_kind) begin
                    next_state.mem.write_addr = indexed_addr;
                    if (dest_indirect) begin
                        // Dropped write leaves the memory bus idle
                        next_state.mem = '0;
                    end
                end else begin
                    next_state.mem.write_addr = insn_word[11:0];
                end
            end
            default: next_state.phase = st_execute;
        endcase
    end

    // Every output is a flop, so the core sees clean one-cycle pulses
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state <= '{phase:       st_execute,
                       move_kind:   1'b0,
                       source_addr: 12'h000,
                       pointer_0:   pointer_reset,
                       pointer_1:   pointer_reset,
                       pointer_2:   pointer_reset,
                       mem:         '0,
                       flow:        '0,
                       handled:     1'b0,
                       busy:        1'b0};
        end else begin
            state <= next_state;
        end
    end

    // Pointers are levels; everything else pulses for one cycle
    assign mem_req               = state.mem;
    assign flow_req              = state.flow;
    assign file_select_pointer_0 = state.pointer_0;
    assign file_select_pointer_1 = state.pointer_1;
    assign third_pointer         = state.pointer_2;
    assign insn_handled          = state.handled;
    assign insn_busy             = state.busy;

endmodule : extended_indexed_instruction_unit

//--- tb/ext_insn_assertions.sv
`timescale 1ns/1ps
module ext_insn_assertions (
    // Clock and reset
    input  wire logic                    mclk,
    input  wire logic                    reset,
    // Inputs
    input  wire logic                    extended_set_enable,
    input  wire logic                    insn_valid,
    input  wire logic [15:0]             insn_word,
    input  wire logic [20:0]             program_counter,
    input  wire logic [7:0]              working_register,
    input  wire logic [7:0]              counter_high_latch,
    input  wire logic [7:0]              counter_upper_latch,
    // Outputs
    input  wire ext_insn_pkg::mem_req_s  mem_req,
    input  wire ext_insn_pkg::flow_req_s flow_req,
    input  wire logic [11:0]             file_select_pointer_0,
    input  wire logic [11:0]             third_pointer,
    input  wire logic                    insn_handled,
    input  wire logic                    insn_busy
);
    import ext_insn_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    // Busy or a pending read marks a word that is not a fresh instruction
    wire logic       take = extended_set_enable && insn_valid && !insn_busy && !mem_req.read;
    wire logic [7:0] op   = insn_word[15:8];
    AST_ADD_SEL0: assert property (take && op == op_add_pointer && insn_word[7:6] == 2'h0
        |=> file_select_pointer_0 == $past(file_select_pointer_0) + $past(insn_word[5:0]))
        else $error("pointer add wrong");
    AST_ADD_RET: assert property (take && op == op_add_pointer && insn_word[7:6] == 2'h3
        |=> flow_req.pop_to_pc && third_pointer == $past(third_pointer) + $past(insn_word[5:0])
        ##1 insn_handled && !flow_req.pop_to_pc) else $error("add and return wrong");
    AST_CALL: assert property (take && insn_word == op_call_via_working
        |=> flow_req.push && flow_req.push_value == $past(program_counter) + 21'h000002
        && flow_req.load && flow_req.value == {$past(counter_upper_latch[4:0]),
        $past(counter_high_latch), $past(working_register)}) else $error("call wrong");
    AST_CALL_DEAD: assert property (take && insn_word == op_call_via_working
        |=> insn_busy ##1 insn_handled && !flow_req.load && !mem_req.write)
        else $error("call second cycle wrong");
    AST_PUSH: assert property (take && op == op_push_literal
        |=> mem_req.write && mem_req.write_addr == $past(third_pointer)
        && mem_req.write_data == $past(insn_word[7:0])
        && third_pointer == $past(third_pointer) - 12'h001) else $error("push wrong");
    AST_MOVE_SRC: assert property (take && op == op_move_indexed
        |=> mem_req.read && mem_req.read_addr == $past(third_pointer) + $past(insn_word[6:0]))
        else $error("move source wrong");
    AST_MOVE_ABS: assert property (take && insn_word[15:7] == {op_move_indexed, 1'b0} ##1 1'b1
        |=> mem_req.write && mem_req.write_addr == $past(insn_word[11:0]))
        else $error("move destination wrong");
    AST_DISABLED: assert property (!extended_set_enable |=> !insn_handled)
        else $error("claimed while disabled");
    COV_CALL: cover property (take && insn_word == op_call_via_working);
    COV_MOVE: cover property (take && op == op_move_indexed);
    COV_PUSH: cover property (take && op == op_push_literal);
endmodule : ext_insn_assertions

//--- tb/data_memory_model.sv
`timescale 1ns/1ps
module data_memory_model (
    // Clock and requests
    input  wire logic                   mclk,
    input  wire ext_insn_pkg::mem_req_s mem_req,
    // Read return
    output logic [7:0]                  mem_read_data
);
    import ext_insn_pkg::*;
    logic [7:0] mem [4096];
    logic [7:0] held = 8'h00;
    logic       hv   = 1'b0;
    initial for (int a = 0; a < 4096; a++) mem[a] = 8'(a) ^ 8'ha5;
    // Byte holds one cycle past the read, then flips so a late sample never matches
    assign mem_read_data = mem_req.read ? mem[mem_req.read_addr] : (hv ? held : ~held);
    always @(posedge mclk) begin
        hv <= mem_req.read;
        if (mem_req.read) held <= mem[mem_req.read_addr];
        if (mem_req.write) mem[mem_req.write_addr] <= mem_req.write_data;
    end
endmodule : data_memory_model

//--- tb/testbench.sv
`timescale 1ns/1ps
bind extended_indexed_instruction_unit ext_insn_assertions chk_u (.mclk, .reset,
    .extended_set_enable, .insn_valid, .insn_word, .program_counter, .working_register,
    .counter_high_latch, .counter_upper_latch, .mem_req, .flow_req, .file_select_pointer_0,
    .third_pointer, .insn_handled, .insn_busy);
module testbench;
    import ext_insn_pkg::*;
    logic        mclk = 0, reset = 1, en = 1, insn_valid = 0, hnd, busy;
    logic [15:0] insn_word = 16'h0000;
    logic [20:0] pc = 21'h001000;
    logic [7:0]  w_reg = 8'h06, lat_h = 8'h10, lat_u = 8'h1f, rd;
    logic [11:0] p0, p1, p2;
    mem_req_s    mem_req;
    flow_req_s   flow_req;
    int          err_total = 0, checks = 0;
    extended_indexed_instruction_unit dut_u (.mclk, .reset, .extended_set_enable(en),
        .insn_valid, .insn_word, .program_counter(pc), .working_register(w_reg),
        .counter_high_latch(lat_h), .counter_upper_latch(lat_u), .mem_read_data(rd), .mem_req,
        .flow_req, .file_select_pointer_0(p0), .file_select_pointer_1(p1), .third_pointer(p2),
        .insn_handled(hnd), .insn_busy(busy));
    data_memory_model mem_u (.mclk, .mem_req, .mem_read_data(rd));
    initial forever #2.5 mclk = ~mclk;
    task chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Word is taken at the next edge; its results are visible on return
    task put(input logic [15:0] w);
        insn_valid = 1;
        insn_word = w;
        @(posedge mclk);
        #1;
    endtask : put
    task t_reset_disable;
        chk({p0, p1, p2, hnd}, 37'h0);
        en = 0;
        put(16'he805);
        chk({hnd, p0}, 13'h000);
        en = 1;
    endtask : t_reset_disable
    task t_pointers;
        for (int s = 0; s < 3; s++) begin
            put({8'he8, 2'(s), 6'h3f});
            chk(s == 0 ? p0 : s == 1 ? p1 : p2, 12'h03f);
            put({8'he9, 2'(s), 6'h01});
            chk(s == 0 ? p0 : s == 1 ? p1 : p2, 12'h03e);
        end
    endtask : t_pointers
    task t_returns;
        put(16'he8c2);
        chk({flow_req.pop_to_pc, p2}, 13'h1040);
        put(16'he8bf);
        chk({hnd, flow_req.pop_to_pc, p2}, 14'h2040);
        put(16'he9c2);
        chk({flow_req.pop_to_pc, p2}, 13'h103e);
        put(16'he9bf);
        chk({hnd, flow_req.pop_to_pc, p2}, 14'h203e);
    endtask : t_returns
    task t_call;
        put(op_call_via_working);
        chk({flow_req.push, flow_req.load, busy}, 3'h7);
        chk(flow_req.push_value, pc + 21'h2);
        chk(flow_req.value, {lat_u[4:0], lat_h, w_reg});
        put(16'he801);
        chk({hnd, flow_req.load, mem_req.write, p0}, 15'h403e);
    endtask : t_call
    task t_push;
        put(16'hea08);
        chk({mem_req.write, mem_req.write_addr, mem_req.write_data, p2}, 33'h103e0803d);
        put(16'he9bf);
        put(16'he9be);
        chk(p2, 12'hfc0);
    endtask : t_push
    // Destinations never name the counter or stack bytes
    task t_move(input logic [15:0] w1, w2, input logic [11:0] dst, input logic [8:0] wd);
        put(w1);
        chk({mem_req.read, mem_req.read_addr}, {1'b1, 12'hfc0 + w1[6:0]});
        put(w2);
        chk({mem_req.write, mem_req.write_addr, mem_req.write_data}, {wd[8], dst, wd[7:0]});
    endtask : t_move
    task t_stray;
        put(16'hf123);
        chk({hnd, mem_req.write, flow_req.load}, 3'h4);
    endtask : t_stray
    task end_of_test;
        $display("errors %0d checks %0d", err_total, checks);
        if (err_total == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test
    initial begin
        #5000;
        err_total++;
        end_of_test;
    end
    initial begin
        repeat (12) @(posedge mclk);
        #1;
        reset = 0;
        t_reset_disable;
        t_pointers;
        t_returns;
        t_call;
        t_push;
        t_move(16'heb10, 16'hff80, 12'hf80, 9'h175);
        t_move(16'heb2f, 16'hf123, 12'h123, 9'h100);
        t_move(16'heb90, 16'hf011, 12'hfd1, 9'h175);
        t_move(16'heb90, 16'hf02f, 12'h000, 9'h000);
        t_move(16'heb30, 16'hf124, 12'h124, 9'h155);
        t_stray;
        end_of_test;
    end
endmodule : testbench
